// *** hw/vector_arb_cfg.svh ***
// named constants of the interrupt vector arbiter: widths, vector slot offsets, hold time
// assumes it is included by bare name from the package and the design modules
`ifndef VECTOR_ARB_CFG_SVH
`define VECTOR_ARB_CFG_SVH

`define BASE_W          16
`define OFS_W           8
`define ADDR_W          24
`define SLOT_W          7
`define NUM_SLOTS       128
`define RANK_W          6
`define RANK_NONE       6'h3f
`define LEVEL_NMI       2'h3
`define CODE_OFF        2'h0
`define HOLD_CYCLES     2'h2

// level 3 slots
`define OFS_HW_RESET    8'h00
`define OFS_STACK_ERR   8'h02
`define OFS_ILLEGAL     8'h04
`define OFS_DEBUG       8'h06
`define OFS_TRAP        8'h08
`define OFS_NMI         8'h0a
// maskable slots
`define OFS_EXT_A       8'h10
`define OFS_EXT_B       8'h12
`define OFS_EXT_C       8'h14
`define OFS_EXT_D       8'h16
`define OFS_DMA0        8'h18
`define OFS_DMA1        8'h1a
`define OFS_DMA2        8'h1c
`define OFS_DMA3        8'h1e
`define OFS_DMA4        8'h20
`define OFS_DMA5        8'h22
`define OFS_T0_CMP      8'h24
`define OFS_T0_OVF      8'h26
`define OFS_T1_CMP      8'h28
`define OFS_T1_OVF      8'h2a
`define OFS_T2_CMP      8'h2c
`define OFS_T2_OVF      8'h2e
`define OFS_SSP0        8'h30
`define OFS_SSP0_RXE    8'h32
`define OFS_SSP0_RXL    8'h34
`define OFS_SSP0_TX     8'h36
`define OFS_SSP0_TXE    8'h38
`define OFS_SSP0_TXL    8'h3a
`define OFS_SSP1        8'h40
`define OFS_SSP1_RXE    8'h42
`define OFS_SSP1_RXL    8'h44
`define OFS_SSP1_TX     8'h46
`define OFS_SSP1_TXE    8'h48
`define OFS_SSP1_TXL    8'h4a
`define OFS_ASP_RX      8'h50
`define OFS_ASP_RXE     8'h52
`define OFS_ASP_TX      8'h54
`define OFS_ASP_IDLE    8'h56
`define OFS_ASP_TMR     8'h58
`define OFS_HOST_RXF    8'h60
`define OFS_HOST_TXE    8'h62
`define OFS_HOST_CMD    8'h64

`endif

// *** hw/vector_arb_pkg.sv ***
// types shared by the interrupt vector arbiter modules
// assumes vector_arb_cfg.svh is on the include path
`include "vector_arb_cfg.svh"

package vector_arb_pkg;
	typedef logic [`SLOT_W-1:0] slot_t;
	typedef logic [`RANK_W-1:0] rank_t;
	typedef logic [1:0]         level_t;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_OFFER,
		ST_HOLD
	} arb_state_t;
endpackage

// *** hw/rank_picker.sv ***
// fixed source order within one priority level: picks the best ranked candidate slot
// assumes the candidate vector already holds only slots of one level
`include "vector_arb_cfg.svh"

module rank_picker (
	input  wire logic [`NUM_SLOTS-1:0]   cand,
	output logic                         found,
	output vector_arb_pkg::slot_t        best_slot
);

	// lower rank wins; level 3 and maskable sources share the numbering
	function automatic vector_arb_pkg::rank_t rank_of(input logic [`OFS_W-1:0] ofs);
		case (ofs)
			`OFS_HW_RESET:  rank_of = 6'h00;
			`OFS_STACK_ERR: rank_of = 6'h01;
			`OFS_ILLEGAL:   rank_of = 6'h02;
			`OFS_DEBUG:     rank_of = 6'h03;
			`OFS_TRAP:      rank_of = 6'h04;
			`OFS_NMI:       rank_of = 6'h05;
			`OFS_EXT_A:     rank_of = 6'h00;
			`OFS_EXT_B:     rank_of = 6'h01;
			`OFS_EXT_C:     rank_of = 6'h02;
			`OFS_EXT_D:     rank_of = 6'h03;
			`OFS_DMA0:      rank_of = 6'h04;
			`OFS_DMA1:      rank_of = 6'h05;
			`OFS_DMA2:      rank_of = 6'h06;
			`OFS_DMA3:      rank_of = 6'h07;
			`OFS_DMA4:      rank_of = 6'h08;
			`OFS_DMA5:      rank_of = 6'h09;
			`OFS_HOST_CMD:  rank_of = 6'h0a;
			`OFS_HOST_TXE:  rank_of = 6'h0b;
			`OFS_HOST_RXF:  rank_of = 6'h0c;
			`OFS_SSP0_RXE:  rank_of = 6'h0d;
			`OFS_SSP0:      rank_of = 6'h0e;
			`OFS_SSP0_RXL:  rank_of = 6'h0f;
			`OFS_SSP0_TXE:  rank_of = 6'h10;
			`OFS_SSP0_TXL:  rank_of = 6'h11;
			`OFS_SSP0_TX:   rank_of = 6'h12;
			`OFS_SSP1_RXE:  rank_of = 6'h13;
			`OFS_SSP1:      rank_of = 6'h14;
			`OFS_SSP1_RXL:  rank_of = 6'h15;
			`OFS_SSP1_TXE:  rank_of = 6'h16;
			`OFS_SSP1_TXL:  rank_of = 6'h17;
			`OFS_SSP1_TX:   rank_of = 6'h18;
			`OFS_ASP_RXE:   rank_of = 6'h19;
			`OFS_ASP_RX:    rank_of = 6'h1a;
			`OFS_ASP_TX:    rank_of = 6'h1b;
			`OFS_ASP_IDLE:  rank_of = 6'h1c;
			`OFS_ASP_TMR:   rank_of = 6'h1d;
			`OFS_T0_OVF:    rank_of = 6'h1e;
			`OFS_T0_CMP:    rank_of = 6'h1f;
			`OFS_T1_OVF:    rank_of = 6'h20;
			`OFS_T1_CMP:    rank_of = 6'h21;
			`OFS_T2_OVF:    rank_of = 6'h22;
			`OFS_T2_CMP:    rank_of = 6'h23;
			default:        rank_of = `RANK_NONE;
		endcase
	endfunction

	// scan all slots, keep the lowest rank seen
	always_comb begin
		vector_arb_pkg::rank_t best_rank;
		best_rank = `RANK_NONE;
		found     = 1'b0;
		best_slot = '0;
		for (int i = 0; i < `NUM_SLOTS; i++) begin
			if (cand[i] && rank_of({7'(i), 1'b0}) < best_rank) begin
				best_rank = rank_of({7'(i), 1'b0});
				best_slot = 7'(i);
				found     = 1'b1;
			end
		end
	end

endmodule // rank_picker

// *** hw/interrupt_vector_priority_arbiter.sv ***
// interrupt vector arbiter: gathers exception and peripheral requests, picks one by level
// and fixed order, and offers its fetch address to the core sequencer
// assumes requests are levels held by each source until it is serviced, all on core_clk
`include "vector_arb_cfg.svh"

module interrupt_vector_priority_arbiter (
	input  wire logic                  core_clk,
	input  wire logic                  reset_n,
	// vector base and core interrupt mask
	input  wire logic [`BASE_W-1:0]    vector_base,
	input  wire logic [1:0]            core_mask,
	// level 3 exception requests
	input  wire logic                  hw_reset_req,
	input  wire logic                  stack_error_req,
	input  wire logic                  illegal_instr_req,
	input  wire logic                  debug_req,
	input  wire logic                  trap_req,
	input  wire logic                  nmi_req,
	// maskable requests
	input  wire logic                  external_request_a,
	input  wire logic                  external_request_b,
	input  wire logic                  external_request_c,
	input  wire logic                  external_request_d,
	input  wire logic [5:0]            dma_req,
	input  wire logic [2:0]            timer_compare_req,
	input  wire logic [2:0]            timer_overflow_req,
	input  wire logic [5:0]            sync_serial_port_0_req,
	input  wire logic [5:0]            sync_serial_port_1_req,
	input  wire logic [4:0]            async_serial_port_req,
	input  wire logic [2:0]            host_req,
	// level codes: 0 off, 1..3 give level 0..2
	input  wire logic [1:0]            ext_a_level,
	input  wire logic [1:0]            ext_b_level,
	input  wire logic [1:0]            ext_c_level,
	input  wire logic [1:0]            ext_d_level,
	input  wire logic [11:0]           dma_level,
	input  wire logic [1:0]            timer_level,
	input  wire logic [1:0]            sync_0_level,
	input  wire logic [1:0]            sync_1_level,
	input  wire logic [1:0]            async_level,
	input  wire logic [1:0]            host_level,
	// core sequencer side
	input  wire logic                  core_take,
	output logic                       irq_valid_q,
	output logic [`ADDR_W-1:0]         vector_addr_q,
	output logic [1:0]                 irq_level_q,
	output logic [`SLOT_W-1:0]         irq_slot_q,
	output logic                       taken_q,
	output logic [`SLOT_W-1:0]         taken_slot_q
);

	// reset release flops
	logic                              rst_meta_q;
	logic                              rst_n_q;
	// per-slot arbitration nets
	logic [`NUM_SLOTS-1:0]             req_v;
	logic [`NUM_SLOTS-1:0]             nmi_v;
	logic [1:0]                        code_v [`NUM_SLOTS];
	logic [`NUM_SLOTS-1:0]             active_v;
	logic [1:0]                        eff_v [`NUM_SLOTS];
	logic [3:0]                        level_seen;
	logic [1:0]                        best_level;
	logic                              any_level;
	logic [`NUM_SLOTS-1:0]             cand_v;
	logic                              found;
	vector_arb_pkg::slot_t             best_slot;
	// offer sequence state
	vector_arb_pkg::arb_state_t        state_q;
	vector_arb_pkg::arb_state_t        state_d;
	logic [1:0]                        hold_q;
	logic                              offer_ok;
	logic                              take_now;

	// slot index of an offset plus a step of whole slots
	function automatic vector_arb_pkg::slot_t slot_at(input logic [`OFS_W-1:0] ofs,
		input int k);
		slot_at = ofs[`OFS_W-1:1] + 7'(k);
	endfunction

	// a request passes a core mask at its own level or below; level 3 always passes
	function automatic logic passes(input logic [1:0] level, input logic [1:0] mask);
		passes = (level >= mask);
	endfunction

	// level code 1..3 stands for level 0..2; code 0 is filtered out before use
	function automatic logic [1:0] level_of(input logic [1:0] code);
		level_of = code - 2'h1;
	endfunction

	// reset release through two flops
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// level 3 exceptions, one slot each
	always_comb begin
		nmi_v = '0;
		nmi_v[slot_at(`OFS_HW_RESET, 0)]  = hw_reset_req;
		nmi_v[slot_at(`OFS_STACK_ERR, 0)] = stack_error_req;
		nmi_v[slot_at(`OFS_ILLEGAL, 0)]   = illegal_instr_req;
		nmi_v[slot_at(`OFS_DEBUG, 0)]     = debug_req;
		nmi_v[slot_at(`OFS_TRAP, 0)]      = trap_req;
		nmi_v[slot_at(`OFS_NMI, 0)]       = nmi_req;
	end

	// map each maskable source to its vector slot with its level code
	always_comb begin
		req_v = '0;
		for (int s = 0; s < `NUM_SLOTS; s++) begin
			code_v[s] = `CODE_OFF;
		end
		req_v[slot_at(`OFS_EXT_A, 0)]     = external_request_a;
		code_v[slot_at(`OFS_EXT_A, 0)]    = ext_a_level;
		req_v[slot_at(`OFS_EXT_B, 0)]     = external_request_b;
		code_v[slot_at(`OFS_EXT_B, 0)]    = ext_b_level;
		req_v[slot_at(`OFS_EXT_C, 0)]     = external_request_c;
		code_v[slot_at(`OFS_EXT_C, 0)]    = ext_c_level;
		req_v[slot_at(`OFS_EXT_D, 0)]     = external_request_d;
		code_v[slot_at(`OFS_EXT_D, 0)]    = ext_d_level;
		for (int c = 0; c < 6; c++) begin
			req_v[slot_at(`OFS_DMA0, c)]  = dma_req[c];
			code_v[slot_at(`OFS_DMA0, c)] = dma_level[2*c +: 2];
			req_v[slot_at(`OFS_SSP0, c)]  = sync_serial_port_0_req[c];
			code_v[slot_at(`OFS_SSP0, c)] = sync_0_level;
			req_v[slot_at(`OFS_SSP1, c)]  = sync_serial_port_1_req[c];
			code_v[slot_at(`OFS_SSP1, c)] = sync_1_level;
		end
		for (int t = 0; t < 3; t++) begin
			req_v[slot_at(`OFS_T0_CMP, 2*t)]  = timer_compare_req[t];
			code_v[slot_at(`OFS_T0_CMP, 2*t)] = timer_level;
			req_v[slot_at(`OFS_T0_OVF, 2*t)]  = timer_overflow_req[t];
			code_v[slot_at(`OFS_T0_OVF, 2*t)] = timer_level;
			req_v[slot_at(`OFS_HOST_RXF, t)]  = host_req[t];
			code_v[slot_at(`OFS_HOST_RXF, t)] = host_level;
		end
		for (int a = 0; a < 5; a++) begin
			req_v[slot_at(`OFS_ASP_RX, a)]  = async_serial_port_req[a];
			code_v[slot_at(`OFS_ASP_RX, a)] = async_level;
		end
	end

	// effective level per slot; reserved slots never carry a request
	always_comb begin
		for (int s = 0; s < `NUM_SLOTS; s++) begin
			if (nmi_v[s]) begin
				active_v[s] = 1'b1;
				eff_v[s]    = `LEVEL_NMI;
			end else begin
				active_v[s] = req_v[s] && (code_v[s] != `CODE_OFF);
				eff_v[s]    = level_of(code_v[s]);
			end
		end
	end

	// which levels have an unmasked request; level 3 passes any mask
	always_comb begin
		level_seen = '0;
		for (int s = 0; s < `NUM_SLOTS; s++) begin
			if (active_v[s] && passes(eff_v[s], core_mask)) begin
				level_seen[eff_v[s]] = 1'b1;
			end
		end
	end

	// highest present level wins before any source order is looked at
	always_comb begin
		any_level  = |level_seen;
		best_level = 2'h0;
		for (int l = 0; l < 4; l++) begin
			if (level_seen[l]) begin
				best_level = 2'(l);
			end
		end
	end

	// candidates are the unmasked requests at the winning level
	always_comb begin
		for (int s = 0; s < `NUM_SLOTS; s++) begin
			cand_v[s] = any_level && active_v[s] && (eff_v[s] == best_level)
				&& passes(eff_v[s], core_mask);
		end
	end

	// fixed order tie break inside the winning level
	rank_picker u_rank_picker (
		.cand      (cand_v),
		.found     (found),
		.best_slot (best_slot)
	);

	// offer is dropped once taken, so no slot is handed out twice
	assign offer_ok = (state_q != vector_arb_pkg::ST_HOLD);

	// the core accepts the standing offer at this edge
	assign take_now = (state_q == vector_arb_pkg::ST_OFFER) && core_take;

	// offer, take and hold-off sequence
	always_comb begin
		state_d = state_q;
		case (state_q)
			vector_arb_pkg::ST_IDLE: begin
				if (found) begin
					state_d = vector_arb_pkg::ST_OFFER;
				end
			end
			vector_arb_pkg::ST_OFFER: begin
				if (core_take) begin
					state_d = vector_arb_pkg::ST_HOLD;
				end else if (!found) begin
					state_d = vector_arb_pkg::ST_IDLE;
				end
			end
			vector_arb_pkg::ST_HOLD: begin
				if (hold_q == 2'h0) begin
					state_d = vector_arb_pkg::ST_IDLE;
				end
			end
			default: state_d = vector_arb_pkg::ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= vector_arb_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// hold-off counter gives the source time to drop its request
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			hold_q <= `HOLD_CYCLES;
		end else if (take_now) begin
			hold_q <= `HOLD_CYCLES;
		end else if (state_q == vector_arb_pkg::ST_HOLD && hold_q != 2'h0) begin
			hold_q <= hold_q - 2'h1;
		end
	end

	// offer flag: up while a winner stands, down from the edge the core takes it
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			irq_valid_q <= 1'b0;
		end else if (take_now) begin
			irq_valid_q <= 1'b0;
		end else begin
			irq_valid_q <= found && offer_ok && state_d != vector_arb_pkg::ST_HOLD;
		end
	end

	// offered vector follows the current winner and freezes once taken
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			vector_addr_q <= '0;
			irq_level_q   <= 2'h0;
			irq_slot_q    <= '0;
		end else if (found && offer_ok && !take_now) begin
			vector_addr_q <= {vector_base, best_slot, 1'b0};
			irq_level_q   <= best_level;
			irq_slot_q    <= best_slot;
		end
	end

	// one-cycle notice that the core took the offer
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			taken_q <= 1'b0;
		end else begin
			taken_q <= take_now;
		end
	end

	// slot of the last take, kept until the next one
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			taken_slot_q <= '0;
		end else if (take_now) begin
			taken_slot_q <= irq_slot_q;
		end
	end

endmodule // interrupt_vector_priority_arbiter

// *** tb/interrupt_vector_priority_arbiter_props.sv ***
// concurrent checks on the arbiter's core sequencer side
// assumes one core_clk domain; raw reset_n disables the checks
`include "vector_arb_cfg.svh"

module arbiter_checker (
	input wire logic               core_clk,
	input wire logic               reset_n,
	input wire logic [`BASE_W-1:0] vector_base,
	input wire logic [1:0]         core_mask,
	input wire logic               hw_reset_req,
	input wire logic               nmi_req,
	input wire logic               external_request_a,
	input wire logic               core_take,
	input wire logic               irq_valid_q,
	input wire logic [`ADDR_W-1:0] vector_addr_q,
	input wire logic [1:0]         irq_level_q,
	input wire logic [`SLOT_W-1:0] irq_slot_q,
	input wire logic               taken_q,
	input wire logic [`SLOT_W-1:0] taken_slot_q
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// offer accepted, reset request followed by an offer
	sequence s_take; irq_valid_q && core_take; endsequence
	sequence s_rst_seen; hw_reset_req ##1 irq_valid_q; endsequence
	property p_addr_slot; irq_valid_q |-> vector_addr_q[7:0] == {irq_slot_q, 1'b0}; endproperty
	property p_addr_base;
		irq_valid_q && $stable(vector_base) |-> vector_addr_q[23:8] == vector_base;
	endproperty
	property p_lvl3_slot; irq_valid_q && irq_level_q == 2'h3 |-> irq_slot_q <= 7'h05; endproperty
	property p_mask;
		irq_valid_q && irq_level_q != 2'h3 |-> irq_slot_q >= 7'h08 && irq_level_q >= $past(core_mask);
	endproperty
	property p_no_resv;
		irq_valid_q |-> !(irq_slot_q inside {7'h06, 7'h07, 7'h1e, 7'h1f, 7'h26, 7'h27, 7'h2d,
			7'h2e, 7'h2f}) && irq_slot_q <= 7'h32;
	endproperty
	property p_rst_wins; s_rst_seen |-> irq_slot_q == 7'h00 && irq_level_q == 2'h3; endproperty
	property p_nmi_ext; nmi_req && external_request_a ##1 irq_valid_q |-> irq_level_q == 2'h3; endproperty
	property p_take;
		s_take |=> taken_q && taken_slot_q == $past(irq_slot_q) ##1 !taken_q;
	endproperty
	property p_hold; s_take |=> !irq_valid_q [*3]; endproperty
	property p_take_cause; $rose(taken_q) |-> $past(irq_valid_q && core_take); endproperty
	a_addr_slot: assert property (p_addr_slot) else $error("offset not slot");
	a_addr_base: assert property (p_addr_base) else $error("base wrong");
	a_lvl3_slot: assert property (p_lvl3_slot) else $error("level 3 slot");
	a_mask: assert property (p_mask) else $error("mask or slot");
	a_no_resv: assert property (p_no_resv) else $error("reserved slot");
	a_rst_wins: assert property (p_rst_wins) else $error("reset lost");
	a_nmi_ext: assert property (p_nmi_ext) else $error("nmi lost");
	a_take: assert property (p_take) else $error("take pulse");
	a_hold: assert property (p_hold) else $error("offer in hold");
	a_take_cause: assert property (p_take_cause) else $error("stray take");
endmodule // arbiter_checker

bind interrupt_vector_priority_arbiter arbiter_checker u_arbiter_checker (
	.core_clk(core_clk), .reset_n(reset_n), .vector_base(vector_base),
	.core_mask(core_mask), .hw_reset_req(hw_reset_req), .nmi_req(nmi_req),
	.external_request_a(external_request_a), .core_take(core_take),
	.irq_valid_q(irq_valid_q), .vector_addr_q(vector_addr_q), .irq_level_q(irq_level_q),
	.irq_slot_q(irq_slot_q), .taken_q(taken_q), .taken_slot_q(taken_slot_q));

// *** tb/core_seq_model.sv ***
// core sequencer model: accepts an offered vector after a chosen lag
// assumes irq_valid_q comes from the arbiter on the same clock
module core_seq_model (
	input  wire logic       core_clk,
	input  wire logic       take_en,
	input  wire logic [1:0] lag,
	input  wire logic       irq_valid_q,
	output logic            core_take
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] wait_q;
	initial begin
		core_take = 1'b0;
		wait_q = 2'h0;
	end
	// count offered cycles, then raise take just after an edge
	always @(posedge core_clk) begin
		wait_q <= #1 irq_valid_q ? wait_q + 2'h1 : 2'h0;
		core_take <= #1 take_en && irq_valid_q && wait_q >= lag;
	end
endmodule // core_seq_model

// *** tb/interrupt_vector_priority_arbiter_tb.sv ***
// testbench: sources driven one by one and stacked, levels and mask varied
// assumes the core model answers offers; request r[i] is priority rank i
module interrupt_vector_priority_arbiter_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk, reset_n, take_en, core_take, irq_valid_q, taken_q;
	logic [41:0] r;
	logic [15:0] base;
	logic [1:0]  core_mask, lv_hi, lv_lo, lag, irq_level_q;
	logic [23:0] vector_addr_q;
	logic [6:0]  irq_slot_q, taken_slot_q;
	int          n_errors = 0;
	int          checks_done = 0;
	// slot offset of each rank
	logic [7:0]  ofs [42] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h10, 8'h12, 8'h14,
		8'h16, 8'h18, 8'h1a, 8'h1c, 8'h1e, 8'h20, 8'h22, 8'h64, 8'h62, 8'h60, 8'h32, 8'h30,
		8'h34, 8'h38, 8'h3a, 8'h36, 8'h42, 8'h40, 8'h44, 8'h48, 8'h4a, 8'h46, 8'h52, 8'h50,
		8'h54, 8'h56, 8'h58, 8'h26, 8'h24, 8'h2a, 8'h28, 8'h2e, 8'h2c};

	interrupt_vector_priority_arbiter u_interrupt_vector_priority_arbiter (
		.core_clk(core_clk), .reset_n(reset_n), .vector_base(base), .core_mask(core_mask),
		.hw_reset_req(r[0]), .stack_error_req(r[1]), .illegal_instr_req(r[2]),
		.debug_req(r[3]), .trap_req(r[4]), .nmi_req(r[5]),
		.external_request_a(r[6]), .external_request_b(r[7]),
		.external_request_c(r[8]), .external_request_d(r[9]), .dma_req(r[15:10]),
		.host_req({r[16], r[17], r[18]}),
		.sync_serial_port_0_req({r[23], r[22], r[24], r[21], r[19], r[20]}),
		.sync_serial_port_1_req({r[29], r[28], r[30], r[27], r[25], r[26]}),
		.async_serial_port_req({r[35], r[34], r[33], r[31], r[32]}),
		.timer_overflow_req({r[40], r[38], r[36]}), .timer_compare_req({r[41], r[39], r[37]}),
		.ext_a_level(lv_hi), .ext_b_level(lv_hi), .ext_c_level(lv_hi), .ext_d_level(lv_hi),
		.dma_level({6{lv_lo}}), .timer_level(lv_lo), .sync_0_level(lv_lo),
		.sync_1_level(lv_lo), .async_level(lv_lo), .host_level(lv_lo),
		.core_take(core_take), .irq_valid_q(irq_valid_q), .vector_addr_q(vector_addr_q),
		.irq_level_q(irq_level_q), .irq_slot_q(irq_slot_q), .taken_q(taken_q),
		.taken_slot_q(taken_slot_q));

	core_seq_model u_core_seq_model (.core_clk(core_clk), .take_en(take_en), .lag(lag),
		.irq_valid_q(irq_valid_q), .core_take(core_take));

	// free running core clock, 8 ns period
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic end_of_test;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic step;
		@(posedge core_clk);
		#1;
	endtask

	// what: 0 offer gone, 1 offer up, 2 take reported
	task automatic wait_until(input int what);
		int k;
		for (k = 0; k < 20; k++) begin
			if (what == 2 ? taken_q === 1'b1 : irq_valid_q === what[0]) return;
			step;
		end
		n_errors++;
		end_of_test;
	endtask

	// each source alone: address, level, slot, then taken by the core
	task automatic s_table;
		int i;
		lv_hi = 2'h2;
		lv_lo = 2'h2;
		take_en = 1'b1;
		for (i = 0; i < 42; i++) begin
			base = 16'ha5c3 + 16'(i);
			lag = 2'(i % 3);
			r = 42'h1 << i;
			wait_until(1);
			chk(vector_addr_q, {base, ofs[i]});
			chk(irq_level_q, i < 6 ? 2'h3 : 2'h1);
			chk(irq_slot_q, ofs[i] >> 1);
			wait_until(2);
			chk(taken_slot_q, ofs[i] >> 1);
			r = '0;
			step;
			chk(taken_q, 1'b0);
			repeat (3) step;
		end
		take_en = 1'b0;
	endtask

	// rank i and all higher ranks pending: rank i must win
	task automatic s_order;
		int i;
		for (i = 0; i < 42; i++) begin
			r = ~42'h0 << i;
			wait_until(1);
			chk(irq_slot_q, ofs[i] >> 1);
			r = '0;
			wait_until(0);
		end
	endtask

	// level before order, mask and disabled code
	task automatic s_level;
		lv_hi = 2'h1;
		lv_lo = 2'h3;
		r = 42'h40 | (42'h1 << 41);
		wait_until(1);
		chk({irq_level_q, irq_slot_q}, {2'h2, 7'h16});
		r = '0;
		wait_until(0);
		core_mask = 2'h3;
		r = 42'h1 << 41;
		repeat (3) step;
		chk(irq_valid_q, 1'b0);
		r = 42'h20 | (42'h1 << 41);
		wait_until(1);
		chk({irq_level_q, irq_slot_q}, {2'h3, 7'h05});
		r = '0;
		wait_until(0);
		core_mask = 2'h0;
		lv_hi = 2'h0;
		r = 42'h40;
		repeat (3) step;
		chk(irq_valid_q, 1'b0);
		lv_hi = 2'h2;
		wait_until(1);
		chk(irq_slot_q, 7'h08);
		r = '0;
		wait_until(0);
		core_mask = 2'h2;
		r = 42'h40;
		repeat (3) step;
		chk(irq_valid_q, 1'b0);
		core_mask = 2'h1;
		wait_until(1);
		chk({irq_level_q, irq_slot_q}, {2'h1, 7'h08});
		r = '0;
		wait_until(0);
		core_mask = 2'h0;
	endtask

	// reset in mid offer: outputs clear, first offer on the third edge after release
	task automatic s_reset;
		lv_hi = 2'h2;
		r = 42'h40;
		wait_until(1);
		reset_n = 1'b0;
		step;
		chk(vector_addr_q, 24'h0);
		chk({irq_valid_q, irq_level_q, irq_slot_q, taken_q}, 24'h0);
		reset_n = 1'b1;
		repeat (2) step;
		chk(irq_valid_q, 1'b0);
		step;
		chk({irq_valid_q, irq_slot_q}, {1'b1, 7'h08});
		r = '0;
		wait_until(0);
	endtask

	initial begin
		reset_n = 1'b0;
		r = '0;
		base = 16'h0000;
		core_mask = 2'h0;
		lv_hi = 2'h0;
		lv_lo = 2'h0;
		lag = 2'h0;
		take_en = 1'b0;
		repeat (20) @(posedge core_clk);
		#1 reset_n = 1'b1;
		repeat (3) step;
		s_table;
		s_order;
		s_level;
		s_reset;
		end_of_test;
	end
endmodule // interrupt_vector_priority_arbiter_tb
